// ==== verilog/cmsc_pkg.sv ====
// constants for the can mode and status control block
// assumes a classic wishbone slave with 32-bit data, byte addressed
package cmsc_pkg;
  // register byte addresses
  localparam logic [3:0] OFS_CONTROL   = 4'h0;  // controller_control
  localparam logic [3:0] OFS_STATUS    = 4'h4;  // controller_status
  localparam logic [3:0] OFS_COMMUNICATION_STATUS   = 4'h8;  // communication_status
  localparam logic [3:0] OFS_IRQ_STAT  = 4'hc;  // sticky event bits
  localparam logic [3:0] OFS_IRQ_MASK  = 4'h0;  // mask, on the second page
  localparam logic       PAGE_LOW      = 1'b0;  // address bit 4 selects page
  localparam logic       PAGE_HIGH     = 1'b1;
  // control field positions
  localparam int CTL_MODE_LSB  = 5;
  localparam int CTL_ABORT_BIT = 4;
  localparam int CTL_WIN_LSB   = 1;
  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h80;  // configuration request
  localparam logic [2:0] MODE_RST    = 3'h4;
  // operating modes
  typedef enum logic [2:0] {
    MODE_NORMAL  = 3'b000,
    MODE_DISABLE = 3'b001,
    MODE_LOOP    = 3'b010,
    MODE_LISTEN  = 3'b011,
    MODE_CONFIG  = 3'b100
  } cmsc_mode_type;
  // interrupt source codes
  localparam logic [2:0] CODE_WAKE = 3'h7;
  localparam logic [2:0] CODE_RX0  = 3'h6;
  localparam logic [2:0] CODE_RX1  = 3'h5;
  localparam logic [2:0] CODE_TX0  = 3'h4;
  localparam logic [2:0] CODE_TX1  = 3'h3;
  localparam logic [2:0] CODE_TX2  = 3'h2;
  localparam logic [2:0] CODE_ERR  = 3'h1;
  localparam logic [2:0] CODE_NONE = 3'h0;
  // sticky event bit positions
  localparam int EV_RX0_OVF = 0;
  localparam int EV_RX1_OVF = 1;
  localparam int EV_MODE    = 2;
  localparam int EV_BUSOFF  = 3;
  localparam int EV_NUM     = 4;
endpackage

// ==== verilog/cmsc_top.sv ====
// mode request, abort, window select, interrupt code and comm status
// assumes engine status inputs are on CLK; wishbone master on CLK
// Operation
// - mode status reports entered mode, codes fixed
// - status bits 3-1 carry top interrupt code
// - codes seven, six, five: wake, rx0, rx1
// - codes four, three, two: tx0, tx1, tx2
// - code one error, zero nothing pending
// - window select accepts interrupt codes unchanged
// - only summary registers live in fast area
// - any warning equals rx or tx warning
// - controller status ignores all writes
// - status bits four and zero read zero
//
// The Wishbone register port and the register offsets were left to the implementer.
module cmsc_top
  import cmsc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        CE,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [4:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             IRQ,
  input  wire logic        WAKE_FLAG,
  input  wire logic        RX0_FLAG,
  input  wire logic        RX1_FLAG,
  input  wire logic        TX0_FLAG,
  input  wire logic        TX1_FLAG,
  input  wire logic        TX2_FLAG,
  input  wire logic        ERR_FLAG,
  input  wire logic [2:0]  MODE_ENTERED,
  input  wire logic        MODE_DONE,
  input  wire logic        RX0_ACCEPT_FULL,
  input  wire logic        RX1_ACCEPT_FULL,
  input  wire logic        BUS_OFF,
  input  wire logic        TX_PASSIVE,
  input  wire logic        RX_PASSIVE,
  input  wire logic        TX_WARN,
  input  wire logic        RX_WARN,
  output logic      [2:0]  MODE_REQUEST,
  output logic             ABORT_ALL_TX,
  output logic      [2:0]  WINDOW_SELECT
);

  // reset release synchroniser
  logic       rst_s1_r;            // first stage
  logic       rst_b_r;             // released reset
  // registers
  logic [7:0] control_r;           // controller_control
  logic [2:0] mode_r;              // reported mode
  logic       rx0_ovf_r;           // sticky overflow zero
  logic       rx1_ovf_r;           // sticky overflow one
  logic [EV_NUM-1:0] ev_r;         // interrupt status
  logic [EV_NUM-1:0] ev_nxt;
  logic [EV_NUM-1:0] mask_r;       // interrupt mask
  logic       busoff_d_r;          // bus-off edge detect
  logic       ack_r;               // bus answer
  logic [31:0] rdata_r;            // read data register

  // bit positions used by the decode, the comm status clear, the outputs and the assertions
  localparam int PAGE_BIT     = 4;                 // address bit picking the page
  localparam int COM_RX0_BIT  = 7;                 // rx0 overflow in comm status
  localparam int COM_RX1_BIT  = 6;                 // rx1 overflow in comm status
  localparam int COM_STAT_LSB = 1;                 // engine levels start here
  localparam int COM_STAT_MSB = 5;                 // bus-off is the top level
  localparam int WIN_MSB      = CTL_WIN_LSB + 2;   // top of window field
  localparam int MODE_MSB     = CTL_MODE_LSB + 2;  // top of mode request field
  localparam int CODE_LSB     = 1;                 // interrupt code low bit
  localparam int CODE_MSB     = 3;                 // interrupt code high bit

  // one register slot: page and offset must both match
  function automatic logic slot_hit(input logic [4:0] adr, input logic pg,
                                    input logic [3:0] ofs);
    slot_hit = (adr[PAGE_BIT] == pg) && (adr[PAGE_BIT-1:0] == ofs);
  endfunction

  // decode
  wire        req       = WB_CYC_I & WB_STB_I & ~ack_r;
  wire        wr        = req & WB_WE_I & WB_SEL_I[0];
  wire        hit_ctl   = slot_hit(WB_ADR_I, PAGE_LOW, OFS_CONTROL);
  wire        hit_sta   = slot_hit(WB_ADR_I, PAGE_LOW, OFS_STATUS);
  wire        hit_com   = slot_hit(WB_ADR_I, PAGE_LOW, OFS_COMMUNICATION_STATUS);
  wire        hit_ist   = slot_hit(WB_ADR_I, PAGE_LOW, OFS_IRQ_STAT);
  wire        hit_msk   = slot_hit(WB_ADR_I, PAGE_HIGH, OFS_IRQ_MASK);
  wire        wr_ctl    = wr & hit_ctl;
  wire        wr_com    = wr & hit_com;
  wire        wr_ist    = wr & hit_ist;
  wire        wr_msk    = wr & hit_msk;

  // prioritised interrupt source code
  wire [2:0]  int_code  = WAKE_FLAG ? CODE_WAKE :
                          RX0_FLAG  ? CODE_RX0  :
                          RX1_FLAG  ? CODE_RX1  :
                          TX0_FLAG  ? CODE_TX0  :
                          TX1_FLAG  ? CODE_TX1  :
                          TX2_FLAG  ? CODE_TX2  :
                          ERR_FLAG  ? CODE_ERR  :
                                      CODE_NONE;
  // read-only controller status, unused bits zero
  wire [7:0]  status_v  = {mode_r, 1'b0, int_code, 1'b0};
  wire        any_warn  = TX_WARN | RX_WARN;
  // comm status layout
  wire [7:0]  communication_status_v = {rx0_ovf_r, rx1_ovf_r, BUS_OFF, TX_PASSIVE,
                           RX_PASSIVE, TX_WARN, RX_WARN, any_warn};
  // sticky sources; set beats clear
  wire [EV_NUM-1:0] ev_set = {BUS_OFF & ~busoff_d_r, MODE_DONE,
                              RX1_ACCEPT_FULL, RX0_ACCEPT_FULL};
  // read mux; fast area holds only these summary registers
  wire [7:0]  rd_byte   = hit_ctl ? control_r :
                          hit_sta ? status_v :
                          hit_com ? communication_status_v :
                          hit_ist ? {4'h0, ev_r} :
                          hit_msk ? {4'h0, mask_r} : 8'h00;

  // event register next value
  always_comb begin
    ev_nxt = ev_r;
    if (wr_ist) begin
      ev_nxt = ev_r & ~WB_DAT_I[EV_NUM-1:0];
    end
    ev_nxt = ev_nxt | ev_set;
  end

  // reset synchroniser
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_r <= 1'b0;
      rst_b_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_b_r  <= rst_s1_r;
    end
  end

  // bus answer and read data
  always_ff @(posedge CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else if (CE) begin
      ack_r   <= req;
      rdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // control register; window takes codes unchanged
  always_ff @(posedge CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      control_r <= CONTROL_RST;
    end else if (CE && wr_ctl) begin
      control_r <= {WB_DAT_I[7:1], 1'b0};
    end
  end

  // reported mode follows the engine, never the bus
  always_ff @(posedge CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      mode_r <= MODE_RST;
    end else if (CE && MODE_DONE) begin
      mode_r <= MODE_ENTERED;
    end
  end

  // overflow flags: set wins, write zero clears
  always_ff @(posedge CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      rx0_ovf_r <= 1'b0;
      rx1_ovf_r <= 1'b0;
    end else if (CE) begin
      rx0_ovf_r <= RX0_ACCEPT_FULL | (rx0_ovf_r & ~(wr_com & ~WB_DAT_I[COM_RX0_BIT]));
      rx1_ovf_r <= RX1_ACCEPT_FULL | (rx1_ovf_r & ~(wr_com & ~WB_DAT_I[COM_RX1_BIT]));
    end
  end

  // interrupt status and mask
  always_ff @(posedge CLK or negedge rst_b_r) begin
    if (!rst_b_r) begin
      ev_r       <= '0;
      mask_r     <= '0;
      busoff_d_r <= 1'b0;
    end else if (CE) begin
      ev_r       <= ev_nxt;
      busoff_d_r <= BUS_OFF;
      if (wr_msk) begin
        mask_r <= WB_DAT_I[EV_NUM-1:0];
      end
    end
  end

  // outputs
  assign WB_ACK_O      = ack_r;
  assign WB_DAT_O      = rdata_r;
  assign IRQ           = |(ev_r & mask_r);
  assign MODE_REQUEST  = control_r[MODE_MSB:CTL_MODE_LSB];
  assign ABORT_ALL_TX  = control_r[CTL_ABORT_BIT];
  assign WINDOW_SELECT = control_r[WIN_MSB:CTL_WIN_LSB];

  // named sequence for the mode hand-off
  sequence done_s;
    MODE_DONE && CE;
  endsequence

  mode_follow_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    done_s |=> mode_r == $past(MODE_ENTERED))
    else $error("mode status did not follow entered mode");
  mode_hold_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    !MODE_DONE |=> $stable(mode_r))
    else $error("mode status changed without entry");
  code_wake_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    WAKE_FLAG |-> status_v[3:1] == CODE_WAKE)
    else $error("wake code wrong");
  code_tx2_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (!WAKE_FLAG && !RX0_FLAG && !RX1_FLAG && !TX0_FLAG && !TX1_FLAG && TX2_FLAG)
    |-> int_code == CODE_TX2)
    else $error("tx2 code wrong");
  code_none_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    !(WAKE_FLAG | RX0_FLAG | RX1_FLAG | TX0_FLAG | TX1_FLAG | TX2_FLAG | ERR_FLAG)
    |-> int_code == CODE_NONE)
    else $error("idle code not zero");
  warn_sum_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    communication_status_v[0] == (TX_WARN | RX_WARN))
    else $error("summary warning wrong");
  unused_zero_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    status_v[4] == 1'b0 && status_v[0] == 1'b0)
    else $error("unused status bits set");
  win_copy_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (CE && wr_ctl) |=> WINDOW_SELECT == $past(WB_DAT_I[WIN_MSB:CTL_WIN_LSB]))
    else $error("window select not taken unchanged");
  ovf_sticky_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (CE && RX0_ACCEPT_FULL) |=> rx0_ovf_r)
    else $error("overflow not set");
  abort_take_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (CE && wr_ctl) |=> ABORT_ALL_TX == $past(WB_DAT_I[CTL_ABORT_BIT]))
    else $error("abort output mismatch");

  // accepted writes to the control and comm status slots
  sequence ctl_write_s;
    CE && wr_ctl;
  endsequence
  sequence com_write_s;
    CE && wr_com;
  endsequence

  // mode request takes the written field
  mode_req_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    ctl_write_s |=> MODE_REQUEST == $past(WB_DAT_I[MODE_MSB:CTL_MODE_LSB]))
    else $error("mode request not taken");

  // writes to the status slot change nothing
  status_ro_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (CE && wr && hit_sta && !MODE_DONE) |=> $stable(mode_r) && $stable(control_r))
    else $error("status write had an effect");

  // read of the status slot carries the code in bits 3-1
  code_read_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (CE && req && hit_sta && RX0_FLAG && !WAKE_FLAG)
    |=> WB_DAT_O[CODE_MSB:CODE_LSB] == CODE_RX0)
    else $error("status read lacks code");

  // rx1 wins below wake and rx0
  code_rx1_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (!WAKE_FLAG && !RX0_FLAG && RX1_FLAG)
    |-> int_code == CODE_RX1)
    else $error("rx1 code wrong");

  // tx0 wins below the receive sources
  code_tx0_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (!WAKE_FLAG && !RX0_FLAG && !RX1_FLAG && TX0_FLAG)
    |-> int_code == CODE_TX0)
    else $error("tx0 code wrong");

  // tx1 wins below tx0
  code_tx1_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (!WAKE_FLAG && !RX0_FLAG && !RX1_FLAG && !TX0_FLAG && TX1_FLAG)
    |-> int_code == CODE_TX1)
    else $error("tx1 code wrong");

  // error is the lowest source
  code_err_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    !(WAKE_FLAG | RX0_FLAG | RX1_FLAG | TX0_FLAG | TX1_FLAG | TX2_FLAG) && ERR_FLAG
    |-> int_code == CODE_ERR)
    else $error("error code wrong");

  // comm status read shows the engine levels in place
  layout_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (CE && req && hit_com) |=> WB_DAT_O[COM_STAT_MSB:COM_STAT_LSB] ==
    $past({BUS_OFF, TX_PASSIVE, RX_PASSIVE, TX_WARN, RX_WARN}))
    else $error("comm status layout wrong");

  // writing zero clears an overflow when no new one arrives
  ovf_clear_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (com_write_s ##0 (!RX0_ACCEPT_FULL && !WB_DAT_I[COM_RX0_BIT])) |=> !rx0_ovf_r)
    else $error("overflow not cleared");

  // overflow stays until a comm status write
  ovf_keep_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (rx0_ovf_r && !wr_com) |=> rx0_ovf_r)
    else $error("overflow dropped");

  // ack is a single cycle pulse
  ack_pulse_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (ack_r && CE) |=> !ack_r)
    else $error("ack held too long");

  // every taken request is answered on the next edge
  ack_answer_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (CE && req) |=> ack_r)
    else $error("request not answered");

  // event set wins over a clear in the same cycle
  ev_set_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (CE && ev_set[EV_RX0_OVF]) |=> ev_r[EV_RX0_OVF])
    else $error("event not captured");

  // low clock enable freezes all state except the reset synchroniser
  ce_freeze_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    !CE |=> $stable(control_r) && $stable(mode_r) && $stable(ev_r) && $stable(ack_r))
    else $error("state moved while frozen");

  // slots outside the fast area read zero
  unmapped_zero_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (CE && req && !(hit_ctl || hit_sta || hit_com || hit_ist || hit_msk))
    |=> WB_DAT_O == 32'h0000_0000)
    else $error("unmapped read not zero");

  // an all-clear mask silences the interrupt
  irq_mask_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    (CE && wr_msk && WB_DAT_I[EV_NUM-1:0] == '0) |=> !IRQ)
    else $error("masked interrupt raised");

  // window select moves only on a control write
  win_hold_a: assert property (@(posedge CLK) disable iff (!rst_b_r)
    !(CE && wr_ctl) |=> $stable(WINDOW_SELECT))
    else $error("window select moved");

endmodule

// ==== tb/cmsc_engine_model.sv ====
// protocol engine stand-in: walks to the requested mode
// assumes the same clock and reset as the block under test
module cmsc_engine_model
  import cmsc_pkg::*;
#(
  parameter int DELAY = 4  // cycles waited before the change is entered
)(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] mode_req,
  output logic      [2:0] mode_now,
  output logic            mode_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_r;  // cycles spent on the pending change
  // enter the request only after a delay, so status must lag it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_now  <= MODE_RST;
      mode_done <= 1'b0;
      wait_r    <= 4'h0;
    end else begin
      mode_done <= 1'b0;
      if (mode_req != mode_now) begin  // change pending
        wait_r <= wait_r + 4'h1;
        if (wait_r == 4'(DELAY)) begin  // entered: one done pulse
          mode_now  <= mode_req;
          mode_done <= 1'b1;
          wait_r    <= 4'h0;
        end
      end
    end
  end
endmodule

// ==== tb/cmsc_top_test.sv ====
// self-checking bench for the mode and status control block
// assumes the package, the block and the engine model compile first
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", n, e, a); end end
module cmsc_top_test
  import cmsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, ce = 1, ack, irq, abrt, done;
  logic [4:0]  adr = 0, st = 0;  // st: bus-off, passives, warnings
  logic [31:0] di = 0, dout, q;  // write data, read data, last read
  logic [6:0]  fl = 0;           // interrupt flags, wake on top
  logic [1:0]  ovf = 0;          // accepted-while-full pulses
  logic [2:0]  req, buffer_window_select, ent;
  logic [2:0]  ml [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h1, 3'h4};
  int miscompares = 0, total_checks = 0;
  always #50 clk = ~clk;
  cmsc_engine_model eng (.clk(clk), .rst_b(rst_b), .mode_req(req), .mode_now(ent),
    .mode_done(done));
  cmsc_top dut (.CLK(clk), .RST_B(rst_b), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(di), .WB_DAT_O(dout),
    .WB_ACK_O(ack), .IRQ(irq), .WAKE_FLAG(fl[6]), .RX0_FLAG(fl[5]), .RX1_FLAG(fl[4]),
    .TX0_FLAG(fl[3]), .TX1_FLAG(fl[2]), .TX2_FLAG(fl[1]), .ERR_FLAG(fl[0]),
    .MODE_ENTERED(ent), .MODE_DONE(done), .RX0_ACCEPT_FULL(ovf[0]),
    .RX1_ACCEPT_FULL(ovf[1]), .BUS_OFF(st[4]), .TX_PASSIVE(st[3]), .RX_PASSIVE(st[2]),
    .TX_WARN(st[1]), .RX_WARN(st[0]), .MODE_REQUEST(req), .ABORT_ALL_TX(abrt),
    .WINDOW_SELECT(buffer_window_select));
  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    di  <= {24'h0, d};
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) miscompares++;
    q = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // one-cycle overflow pulse, then let the event land
  task automatic pulse(input logic [1:0] m);
    @(posedge clk);
    ovf <= m;
    @(posedge clk);
    ovf <= 2'b00;
    @(posedge clk);
  endtask
  // prints the counts and the verdict, then stops
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // code priority, code copied into the window, abort, read-only status
  task automatic t_code;
    for (int i = 0; i < 7; i++) begin
      fl <= 7'h7f >> (6 - i);
      wb(0, 5'h04, 8'h0);
      `CHK("code", 8'h80 | 8'(2 * i + 2), q[7:0])
      fl <= 7'h01 << i;
      wb(1, 5'h00, 8'h80 | (q[7:0] & 8'h0e));
      repeat (2) @(posedge clk);
      `CHK("window", 3'(i + 1), buffer_window_select)
      wb(0, 5'h04, 8'h0);
      `CHK("lone code", 8'h80 | 8'(2 * i + 2), q[7:0])
    end
    fl <= 7'h00;
    wb(1, 5'h04, 8'hff);
    `CHK("no code", 8'h80, q[7:0])
    wb(0, 5'h04, 8'h0);
    `CHK("status ro", 8'h80, q[7:0])
    wb(1, 5'h00, 8'h91);
    wb(0, 5'h00, 8'h0);
    `CHK("control", 8'h90, q[7:0])
    `CHK("abort", 1'b1, abrt)
    wb(1, 5'h00, 8'h80);
    repeat (2) @(posedge clk);
    `CHK("abort off", 1'b0, abrt)
    wb(0, 5'h14, 8'h0);
    `CHK("unmapped", 32'h0, q)
    $display("code test done");
  endtask
  // status lags each request until the engine has entered it
  task automatic t_mode;
    logic [2:0] prev;
    prev = 3'h4;
    foreach (ml[k]) begin
      wb(1, 5'h00, {ml[k], 5'h0});
      wb(0, 5'h04, 8'h0);
      `CHK("mode early", prev, q[7:5])
      `CHK("request", ml[k], req)
      repeat (12) @(posedge clk);
      wb(0, 5'h04, 8'h0);
      `CHK("mode", ml[k], q[7:5])
      prev = ml[k];
    end
    $display("mode test done");
  endtask
  // communication status layout, summary warning, sticky overflows
  task automatic t_comm;
    for (int i = 0; i < 32; i++) begin
      st <= i[4:0];
      wb(0, 5'h08, 8'h0);
      `CHK("comm", {2'b00, i[4:0], i[1] | i[0]}, q[7:0])
    end
    st <= 5'h0;
    pulse(2'b01);
    wb(0, 5'h08, 8'h0);
    `CHK("ovf0", 8'h80, q[7:0])
    pulse(2'b10);
    wb(0, 5'h08, 8'h0);
    `CHK("ovf both", 8'hc0, q[7:0])
    wb(1, 5'h08, 8'h40);
    wb(0, 5'h08, 8'h0);
    `CHK("ovf clear", 8'h40, q[7:0])
    ce <= 1'b0;
    pulse(2'b01);
    ce <= 1'b1;
    wb(0, 5'h08, 8'h0);
    `CHK("frozen", 8'h40, q[7:0])
    $display("comm test done");
  endtask
  // event status, mask and write-one-to-clear
  task automatic t_irq;
    wb(1, 5'h0c, 8'hff);
    wb(1, 5'h10, 8'h01);
    @(posedge clk);
    `CHK("irq idle", 1'b0, irq)
    pulse(2'b01);
    `CHK("irq set", 1'b1, irq)
    wb(1, 5'h0c, 8'h02);
    wb(0, 5'h0c, 8'h0);
    `CHK("events", 8'h01, q[7:0])
    wb(1, 5'h0c, 8'h01);
    @(posedge clk);
    `CHK("irq clear", 1'b0, irq)
    wb(1, 5'h10, 8'h00);
    pulse(2'b01);
    `CHK("irq masked", 1'b0, irq)
    $display("irq test done");
  endtask
  // reset, then every scenario in turn
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    wb(0, 5'h00, 8'h0);
    `CHK("control rst", 8'h80, q[7:0])
    t_code();
    t_mode();
    t_comm();
    t_irq();
    test_done();
  end
  // cut a hang short
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule
